// ### inc/sbpc_pkg.sv
// shared constants and types for the sdram command, burst and power control block
package sbpc_pkg;

  // apb register map (byte addresses)
  localparam logic [7:0] SBPC_CFG_OFS  = 8'h00;
  localparam logic [7:0] SBPC_STAT_OFS = 8'h04;

  // burst length codes in cfg.bl
  localparam logic [2:0] SBPC_BL_1    = 3'h0;
  localparam logic [2:0] SBPC_BL_2    = 3'h1;
  localparam logic [2:0] SBPC_BL_4    = 3'h2;
  localparam logic [2:0] SBPC_BL_8    = 3'h3;
  localparam logic [2:0] SBPC_BL_FULL = 3'h7;

  // column read latency codes in cfg.cl
  localparam logic [1:0] SBPC_CL2 = 2'h2;
  localparam logic [1:0] SBPC_CL3 = 2'h3;

  // address bit that carries precharge_flag_bit
  localparam int unsigned SBPC_PF_BIT = 10;

  // write_recovery_time in clocks after the last write beat
  localparam logic [1:0] SBPC_WR_REC_CYC = 2'h2;

  typedef enum logic [3:0] {
    SBPC_RUN  = 4'h1,
    SBPC_SUSP = 4'h2,
    SBPC_PDN  = 4'h4,
    SBPC_SREF = 4'h8
  } sbpc_mode_t;

  // config register layout: cl at 5:4, bt at 3, bl at 2:0
  typedef struct packed {
    logic [25:0] rsvd;
    logic [1:0]  cl;
    logic        bt;
    logic [2:0]  bl;
  } sbpc_cfg_t;

  // status register layout
  typedef struct packed {
    logic [22:0] rsvd;
    logic        wr_rec;
    logic        b_wr;
    logic        b_act;
    logic [1:0]  bank_open;
    logic [3:0]  mode;
  } sbpc_stat_t;

  // burst length 8, sequential, latency 3
  localparam sbpc_cfg_t SBPC_CFG_RST = '{rsvd: 26'h0, cl: 2'h3, bt: 1'b0, bl: 3'h3};

  typedef struct packed {
    logic        chip_select_n;
    logic        row_strobe_n;
    logic        column_strobe_n;
    logic        write_enable_n;
    logic        clock_enable_in;
    logic        region_select;
    logic [10:0] addr;
  } sbpc_pins_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        bank;
    logic [7:0]  col;
    logic [15:0] wdata;
  } sbpc_arr_t;

  typedef struct packed {
    sbpc_mode_t  mode;
    logic        cke_q;
    logic [1:0]  bank_open;
    logic        b_act;
    logic        b_wr;
    logic        b_ap;
    logic        b_bank;
    logic [7:0]  b_start;
    logic [7:0]  b_beat;
    logic [8:0]  b_left;
    logic [1:0]  wr_ap_cnt;
    logic        wr_ap_bank;
    sbpc_arr_t   arr;
    logic        rd_v;
    logic [15:0] rd_d;
    logic        dq_oe;
    logic [15:0] dq_d;
    sbpc_cfg_t   cfg;
    logic [31:0] prdata;
    logic        pslverr;
  } sbpc_state_t;

  localparam sbpc_state_t SBPC_STATE_RST = '{mode: SBPC_RUN, cfg: SBPC_CFG_RST, arr: '0, default: '0};

endpackage : sbpc_pkg

// ### design/sbpc_ctrl.sv
// sdram device-side command decode, burst sequencing, precharge and power modes
//
// Functional notes
// (RQ1) burst-stop command ends a full-page burst, bank stays open
// (RQ2) read cut by burst-stop floats data lines after read latency clocks
// (RQ3) write data after a burst-stop during full-page write is dropped
// (RQ4) sequential order increments column, wrapping in low 1/2/3 bits
// (RQ5) interleaved order xors low start column bits with beat count
// (RQ6) precharge flag bit high on read or write selects auto-precharge
// (RQ7) read auto-precharge starts a latency-dependent number of clocks before burst end
// (RQ8) controller issues no read, write or precharge during auto-precharge bursts
// (RQ9) controller never asks auto-precharge with full-page bursts
// (RQ10) write auto-precharge starts two clocks after the last write beat
// (RQ11) controller waits write recovery plus precharge time before reactivating
// (RQ12) controller keeps active minimum time before internal precharge starts
// (RQ13) precharge command closes one bank or all banks
// (RQ14) controller waits precharge time and reactivates before accessing the bank
// (RQ15) controller enters self-refresh only with all banks idle
// (RQ16) self-refresh ignores all but clock enable, exits when it rises
// (RQ17) controller waits row cycle time after self-refresh exit
// (RQ18) controller should burst auto-refresh around self-refresh
// (RQ19) clock enable low while idle enters power-down, receivers gated
// (RQ20) controller exits power-down with a no-operation then waits
// (RQ21) no-operation and deselect change nothing and keep bursts running
// (RQ22) clock enable low with a bank open suspends one clock later
// (RQ23) flag high closes all banks, low closes only the selected bank
`timescale 1ns/1ps
module sbpc_ctrl (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [7:0]          paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire sbpc_pkg::sbpc_pins_t pins,
  input  wire logic [15:0]         data_lines_in,
  output logic      [15:0]         data_lines_out,
  output logic                     data_lines_oe,
  output sbpc_pkg::sbpc_arr_t      array_req,
  input  wire logic [15:0]         array_rdata
);
  import sbpc_pkg::*;

  sbpc_state_t s_r;
  sbpc_state_t s_nxt;

  function automatic logic [7:0] wrap_mask(input logic [2:0] bl);
    logic [7:0] m;
    case (bl)
      SBPC_BL_1:    m = 8'h00;
      SBPC_BL_2:    m = 8'h01;
      SBPC_BL_4:    m = 8'h03;
      SBPC_BL_8:    m = 8'h07;
      default:      m = 8'hff;
    endcase
    return m;
  endfunction : wrap_mask

  function automatic logic [8:0] burst_len(input logic [2:0] bl);
    logic [8:0] n;
    case (bl)
      SBPC_BL_1: n = 9'h001;
      SBPC_BL_2: n = 9'h002;
      SBPC_BL_4: n = 9'h004;
      SBPC_BL_8: n = 9'h008;
      default:   n = 9'h100;
    endcase
    return n;
  endfunction : burst_len

  // column of a beat; full page always counts sequentially over the whole row
  function automatic logic [7:0] col_of(input logic [7:0] start, input logic [7:0] beat, input sbpc_cfg_t c);
    logic [7:0] m;
    logic [7:0] lo;
    m = wrap_mask(c.bl);
    if (c.bt && c.bl != SBPC_BL_FULL) begin
      lo = start ^ beat; // RQ5
    end else begin
      lo = 8'(start + beat); // RQ4
    end
    return (start & ~m) | (lo & m); // RQ4
  endfunction : col_of

  // command decode and working copies of the burst
  logic       cmd_ok;
  logic       is_act;
  logic       is_pre;
  logic       is_rd;
  logic       is_wr;
  logic       is_bst;
  logic       is_sref;
  logic       busy;
  logic       act;
  logic       wr;
  logic       ap;
  logic       bk;
  logic [7:0] st;
  logic [7:0] bt;
  logic [8:0] lf;
  logic [8:0] lf_after;
  logic [8:0] ap_lead;
  logic       full;
  sbpc_stat_t stat;

  always_comb begin
    s_nxt = s_r;
    s_nxt.cke_q = pins.clock_enable_in;

    stat = '0;
    stat.mode = s_r.mode;
    stat.bank_open = s_r.bank_open;
    stat.b_act = s_r.b_act;
    stat.b_wr = s_r.b_wr;
    stat.wr_rec = (s_r.wr_ap_cnt != 2'h0);

    // apb: read data and error latched in setup, write lands on the access edge
    if (psel && !penable) begin
      s_nxt.pslverr = 1'b0;
      case (paddr)
        SBPC_CFG_OFS:  s_nxt.prdata = s_r.cfg;
        SBPC_STAT_OFS: s_nxt.prdata = stat;
        default: begin
          s_nxt.prdata = 32'h0;
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && pwrite && paddr == SBPC_CFG_OFS) begin
      s_nxt.cfg = pwdata;
      s_nxt.cfg.rsvd = '0;
    end

    // only chip select low with the strobes counts; nop and deselect fall through
    is_act  = !pins.chip_select_n && !pins.row_strobe_n && pins.column_strobe_n && pins.write_enable_n;
    is_pre  = !pins.chip_select_n && !pins.row_strobe_n && pins.column_strobe_n && !pins.write_enable_n;
    is_rd   = !pins.chip_select_n && pins.row_strobe_n && !pins.column_strobe_n && pins.write_enable_n;
    is_wr   = !pins.chip_select_n && pins.row_strobe_n && !pins.column_strobe_n && !pins.write_enable_n;
    is_bst  = !pins.chip_select_n && pins.row_strobe_n && pins.column_strobe_n && !pins.write_enable_n; // RQ1
    is_sref = !pins.chip_select_n && !pins.row_strobe_n && !pins.column_strobe_n && pins.write_enable_n
              && !pins.clock_enable_in;
    busy = (|s_r.bank_open) || s_r.b_act || (s_r.wr_ap_cnt != 2'h0);
    cmd_ok = (s_r.mode == SBPC_RUN) && s_r.cke_q;

    act = s_r.b_act;
    wr = s_r.b_wr;
    ap = s_r.b_ap;
    bk = s_r.b_bank;
    st = s_r.b_start;
    bt = s_r.b_beat;
    lf = s_r.b_left;
    lf_after = 9'h000;
    full = (s_r.cfg.bl == SBPC_BL_FULL);
    ap_lead = (s_r.cfg.cl == SBPC_CL2) ? 9'h000 : 9'h001;

    // power modes
    case (s_r.mode)
      SBPC_RUN: begin
        if (!pins.clock_enable_in) begin
          if (is_sref && s_r.cke_q && !busy) begin
            s_nxt.mode = SBPC_SREF; // RQ16
          end else if (busy) begin
            s_nxt.mode = SBPC_SUSP; // RQ22
          end else begin
            s_nxt.mode = SBPC_PDN; // RQ19
          end
        end
      end
      SBPC_SUSP: begin
        if (pins.clock_enable_in) begin
          s_nxt.mode = SBPC_RUN; // RQ22
        end
      end
      SBPC_PDN: begin
        if (pins.clock_enable_in) begin
          s_nxt.mode = SBPC_RUN; // RQ19
        end
      end
      SBPC_SREF: begin
        if (pins.clock_enable_in) begin
          s_nxt.mode = SBPC_RUN; // RQ16
        end
      end
      default: s_nxt.mode = SBPC_RUN;
    endcase

    // everything below advances only while running; suspend freezes it whole,
    // including the array request, which the array simply sees repeated
    if (s_r.mode == SBPC_RUN) begin // RQ22
      // read data path: array answers in the same cycle as the request
      s_nxt.rd_v = s_r.arr.valid && !s_r.arr.write;
      s_nxt.rd_d = array_rdata;
      if (s_r.cfg.cl == SBPC_CL2) begin
        s_nxt.dq_oe = s_r.arr.valid && !s_r.arr.write;
        s_nxt.dq_d = array_rdata;
      end else begin
        s_nxt.dq_oe = s_r.rd_v; // RQ2
        s_nxt.dq_d = s_r.rd_d;
      end

      // write recovery before the auto-precharge of a write
      if (s_r.wr_ap_cnt != 2'h0) begin
        s_nxt.wr_ap_cnt = s_r.wr_ap_cnt - 2'h1;
        if (s_r.wr_ap_cnt == 2'h1) begin
          s_nxt.bank_open[s_r.wr_ap_bank] = 1'b0; // RQ10
        end
      end

      if (cmd_ok) begin // RQ21
        if (is_act) begin
          s_nxt.bank_open[pins.region_select] = 1'b1;
        end
        if (is_pre) begin
          if (pins.addr[SBPC_PF_BIT]) begin
            s_nxt.bank_open = 2'b00; // RQ23
            act = 1'b0;
          end else begin
            s_nxt.bank_open[pins.region_select] = 1'b0; // RQ13
            if (bk == pins.region_select) begin
              act = 1'b0;
            end
          end
        end
        if ((is_rd || is_wr) && s_r.bank_open[pins.region_select]) begin
          act = 1'b1;
          wr = is_wr;
          ap = pins.addr[SBPC_PF_BIT] && !full; // RQ6
          bk = pins.region_select;
          st = pins.addr[7:0];
          bt = 8'h00;
          lf = burst_len(s_r.cfg.bl);
        end
        if (is_bst && full) begin
          act = 1'b0; // RQ1
        end
      end

      // issue one beat per clock; a stopped write beat never reaches the array
      s_nxt.arr.valid = 1'b0;
      if (act) begin // RQ3
        s_nxt.arr.valid = 1'b1;
        s_nxt.arr.write = wr;
        s_nxt.arr.bank = bk;
        s_nxt.arr.col = col_of(st, bt, s_r.cfg);
        s_nxt.arr.wdata = data_lines_in;
        lf_after = lf - 9'h001;
        if (ap && wr && lf_after == 9'h000) begin
          s_nxt.wr_ap_cnt = SBPC_WR_REC_CYC; // RQ10
          s_nxt.wr_ap_bank = bk;
          ap = 1'b0;
        end
        if (ap && !wr && lf_after <= ap_lead) begin
          s_nxt.bank_open[bk] = 1'b0; // RQ7
          ap = 1'b0;
        end
        bt = bt + 8'h01;
        if (!full) begin
          lf = lf_after;
          act = (lf_after != 9'h000);
        end
      end
      s_nxt.b_act = act;
      s_nxt.b_wr = wr;
      s_nxt.b_ap = ap;
      s_nxt.b_bank = bk;
      s_nxt.b_start = st;
      s_nxt.b_beat = bt;
      s_nxt.b_left = lf;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= SBPC_STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // zero-wait apb slave
  assign pready = psel && penable;
  assign prdata = s_r.prdata;
  assign pslverr = s_r.pslverr;
  assign data_lines_out = s_r.dq_d;
  assign data_lines_oe = s_r.dq_oe;
  assign array_req = s_r.arr;

endmodule : sbpc_ctrl

// ### testbench/sbpc_sva.sv
// concurrent checks on the ports of the sdram command block
`timescale 1ns/1ps
module sbpc_sva (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic [7:0]           paddr,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire sbpc_pkg::sbpc_pins_t pins,
  input wire logic                 data_lines_oe,
  input wire sbpc_pkg::sbpc_arr_t  array_req
);
  import sbpc_pkg::*;
  logic       cke_d;
  logic [3:0] c;
  logic       ok;
  // clock enable of the edge before, so a command counts only when it is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cke_d <= 1'b0;
    else cke_d <= pins.clock_enable_in;
  end
  assign c  = {pins.chip_select_n, pins.row_strobe_n, pins.column_strobe_n, pins.write_enable_n};
  assign ok = cke_d && pins.clock_enable_in;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_stop_no_beat: assert property (ok && c == 4'b0110 |=> !array_req.valid)
    else $error("array beat after burst stop");
  a_stop_float: assert property (ok && c == 4'b0110 |-> ##[2:3] !data_lines_oe)
    else $error("data lines still driven after burst stop");
  a_pre_all_stop: assert property (ok && c == 4'b0010 && pins.addr[SBPC_PF_BIT] |=> ##1 !array_req.valid)
    else $error("burst runs on after precharge all");
  a_susp_freeze: assert property (!pins.clock_enable_in && array_req.valid |=> ##1 $stable(array_req))
    else $error("burst not frozen one clock after enable low");
  a_susp_resume: assert property ($rose(pins.clock_enable_in) |=> $stable(array_req))
    else $error("resume came without the one clock delay");
  a_lowpwr_quiet: assert property (!pins.clock_enable_in && !cke_d && !array_req.valid |=> !array_req.valid)
    else $error("array access while clock enable held low");
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("no zero wait answer");
  a_apb_unmapped: assert property (psel && !penable && paddr != SBPC_CFG_OFS && paddr != SBPC_STAT_OFS
    |=> pslverr && prdata == 32'h0)
    else $error("unmapped address not refused");
endmodule : sbpc_sva

// ### testbench/sbpc_array_model.sv
// array side model: pattern read data, inverted last word while idle
`timescale 1ns/1ps
module sbpc_array_model (
  input  wire logic                pclk,
  input  wire sbpc_pkg::sbpc_arr_t array_req,
  output logic [15:0]              array_rdata
);
  import sbpc_pkg::*;
  logic [15:0] last_r = 16'h0;
  logic [15:0] pat;
  assign pat = {3'h5, array_req.bank, 4'h0, array_req.col};
  // idle bus never repeats old data, so stale captures show up
  assign array_rdata = array_req.valid ? pat : ~last_r;
  always_ff @(posedge pclk) begin
    if (array_req.valid) last_r <= pat;
  end
endmodule : sbpc_array_model

// ### testbench/tb_top.sv
// self-checking bench for the sdram command block
`timescale 1ns/1ps
module tb_top;
  import sbpc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, oe;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [15:0] din, dout, ard;
  sbpc_pins_t  pins;
  sbpc_arr_t   areq;
  int          failures = 0, checks_done = 0;
  localparam int AREF_BURST = 4096;
  always #2 pclk = ~pclk;
  sbpc_ctrl dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .data_lines_in(din), .data_lines_out(dout), .data_lines_oe(oe), .array_req(areq), .array_rdata(ard));
  sbpc_array_model u_arr (.pclk(pclk), .array_req(areq), .array_rdata(ard));
  task automatic wrap_up;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic st(input logic [5:0] e);
    apb(1'b0, SBPC_STAT_OFS, 32'h0, r);
    chk(r[5:0], e);
  endtask : st
  task automatic cfg(input logic [31:0] d);
    apb(1'b1, SBPC_CFG_OFS, d, r);
  endtask : cfg
  task automatic cmd(input logic [3:0] c, input logic b, input logic [10:0] a);
    @(posedge pclk);
    pins <= {c, pins.clock_enable_in, b, a};
  endtask : cmd
  function automatic logic [7:0] colx(input logic [7:0] a, input logic [7:0] m, input int j, input logic bt);
    return bt ? a ^ j[7:0] : (a & ~m) | ((a + j[7:0]) & m);
  endfunction : colx
  // read burst under deselect, latency 3: beat i drives the lines two edges after its array access
  task automatic rd(input logic [10:0] a, input int n, input logic bt);
    cmd(4'b0101, 1'b0, a);
    for (int j = 0; j < n + 3; j++) begin
      @(posedge pclk);
      pins.chip_select_n <= 1'b1;
      #1;
      if (j < n) chk({areq.valid, areq.col}, {1'b1, colx(a[7:0], n[7:0] - 8'h1, j, bt)});
      if (j >= 2) chk(oe, j < n + 2);
      if (j >= 2 && j < n + 2) chk(dout, 16'ha000 | colx(a[7:0], n[7:0] - 8'h1, j - 2, bt));
    end
  endtask : rd
  task automatic wr(input logic [10:0] a, input int n, input logic [7:0] m, input logic s);
    cmd(4'b0100, 1'b0, a);
    din <= 16'h1000;
    for (int j = 0; j <= n; j++) begin
      @(posedge pclk);
      din <= 16'h1001 + 16'(j);
      pins <= {(s && j == n - 1) ? 4'b0110 : 4'b1111, 13'h1000};
      #1;
      if (j < n) chk({areq.valid, areq.write, areq.col, areq.wdata},
                     {2'b11, colx(a[7:0], m, j, 1'b0), 16'h1000 + 16'(j)});
      else chk(areq.valid, 1'b0);
    end
  endtask : wr
  task automatic t_regs;
    apb(1'b0, SBPC_CFG_OFS, 32'h0, r);
    chk(r, 32'h33);
    apb(1'b1, 8'h10, 32'hffffffff, r);
    chk(r, 32'h0);
    chk(pslverr, 1'b1);
    apb(1'b1, SBPC_STAT_OFS, 32'hffffffff, r);
    chk(pslverr, 1'b0);
    st(6'h01);
  endtask : t_regs
  task automatic t_bursts;
    cmd(4'b0011, 1'b0, 11'h0);
    rd(11'h02d, 8, 1'b0);
    cfg(32'h3a);
    rd(11'h02d, 4, 1'b1);
    cfg(32'h39);
    rd(11'h02d, 2, 1'b1);
    cfg(32'h30);
    rd(11'h02d, 1, 1'b0);
    cfg(32'h33);
    rd(11'h42d, 8, 1'b0);
    st(6'h01);
  endtask : t_bursts
  // full-page read cut by burst stop after three beats; lines float cl clocks after the stop
  task automatic rstop(input logic [1:0] cl);
    cfg({26'h0, cl, 4'h7});
    cmd(4'b0101, 1'b0, 11'h0fe);
    for (int j = 0; j < 8; j++) begin
      @(posedge pclk);
      pins.chip_select_n <= (j != 2);
      pins.column_strobe_n <= 1'b1;
      pins.write_enable_n <= (j != 2);
      #1;
      chk(areq.valid, j < 3);
      chk(oe, j >= cl - 1 && j <= cl + 1);
    end
  endtask : rstop
  task automatic t_rstop;
    cmd(4'b0011, 1'b0, 11'h0);
    rstop(SBPC_CL3);
    rstop(SBPC_CL2);
    st(6'h11);
    cmd(4'b0101, 1'b0, 11'h0);
    cmd(4'b0010, 1'b0, 11'h400);
    @(posedge pclk);
    #1;
    chk(areq.valid, 1'b0);
    cfg(32'h33);
    st(6'h01);
  endtask : t_rstop
  task automatic t_wstop;
    cmd(4'b0011, 1'b0, 11'h0);
    cfg(32'h37);
    wr(11'h0fe, 3, 8'hff, 1'b1);
    st(6'h11);
    cfg(32'h33);
    wr(11'h4f9, 8, 8'h07, 1'b0);
    repeat (3) @(posedge pclk);
    st(6'h01);
  endtask : t_wstop
  task automatic t_pre;
    cmd(4'b0011, 1'b0, 11'h0);
    cmd(4'b0011, 1'b1, 11'h0);
    st(6'h31);
    cmd(4'b0010, 1'b1, 11'h0);
    st(6'h11);
    cmd(4'b0010, 1'b1, 11'h400);
    st(6'h01);
  endtask : t_pre
  task automatic t_power;
    cmd(4'b0011, 1'b0, 11'h0);
    cmd(4'b0101, 1'b0, 11'h0);
    cmd(4'b1111, 1'b0, 11'h0);
    @(posedge pclk);
    pins.clock_enable_in <= 1'b0;
    st(6'h12);
    pins.clock_enable_in <= 1'b1;
    repeat (12) @(posedge pclk);
    st(6'h11);
    cmd(4'b0010, 1'b0, 11'h400);
    cmd(4'b1111, 1'b0, 11'h0);
    @(posedge pclk);
    pins.clock_enable_in <= 1'b0;
    st(6'h04);
    pins.clock_enable_in <= 1'b1;
    cmd(4'b0111, 1'b0, 11'h0);
    repeat (4) @(posedge pclk);
    repeat (AREF_BURST) cmd(4'b0001, 1'b0, 11'h0);
    @(posedge pclk);
    pins <= {4'b0001, 13'h0};
    @(posedge pclk);
    pins.chip_select_n <= 1'b1;
    st(6'h08);
    pins.clock_enable_in <= 1'b1;
    repeat (8) @(posedge pclk);
    st(6'h01);
    repeat (AREF_BURST) cmd(4'b0001, 1'b0, 11'h0);
  endtask : t_power
  initial begin
    pins = {4'b1111, 13'h1000};
    din = 16'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_bursts;
    t_rstop;
    t_wstop;
    t_pre;
    t_power;
    wrap_up;
  end
  // a hang is cut at twenty thousand clocks, over twice the roughly 8400 clocks the tests need, mostly refresh bursts
  initial begin
    #80000;
    failures++;
    wrap_up;
  end
endmodule : tb_top
bind sbpc_ctrl sbpc_sva u_sva (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins), .data_lines_oe(data_lines_oe),
  .array_req(array_req));
